// ---- common/ecrmw_pkg.sv ----
// Purpose: Shared constants and types for the ECC read-modify-write memory interface
// Assumes: 10 MHz system clock, 16 data bits, 6 check bits
// Notes:   Check code is a single-error-correcting, double-detecting Hamming code

package ecrmw_pkg;

  localparam int DATA_W = 16;
  localparam int CHK_W  = 6;
  localparam int NSYNC  = 7;

  // Clock and delay figures
  localparam int CLK_PERIOD_NS  = 100;
  localparam int DELAY1_NS      = 150;
  localparam int DELAY2_NS      = 200;
  localparam int DELAY2_GAP_NS  = 42;
  localparam int DELAY1_CYC     = (DELAY1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY2_FLOOR   = (DELAY1_CYC * CLK_PERIOD_NS + DELAY2_GAP_NS
                                   + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY2_NOM     = (DELAY2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY2_CYC     = (DELAY2_FLOOR > DELAY2_NOM) ? DELAY2_FLOOR : DELAY2_NOM;
  localparam logic [3:0] CNT_D1 = 4'(DELAY1_CYC);
  localparam logic [3:0] CNT_D2 = 4'(DELAY2_CYC);

  // Positions of synchronised control pins
  localparam int SY_CAS = 0;
  localparam int SY_ACK = 1;
  localparam int SY_RD  = 2;
  localparam int SY_WR  = 3;
  localparam int SY_CS  = 4;
  localparam int SY_A0  = 5;
  localparam int SY_BHE = 6;
  localparam logic [NSYNC-1:0] SYNC_RST = 7'h7f;

  // Parity-check matrix columns for each data bit, all weight three
  localparam logic [15:0][5:0] HCOL = {
    6'h2c, 6'h2a, 6'h29, 6'h26, 6'h25, 6'h23, 6'h1c, 6'h1a,
    6'h19, 6'h16, 6'h15, 6'h13, 6'h0e, 6'h0d, 6'h0b, 6'h07};

  typedef enum logic [3:0] {
    ECRMW_IDLE   = 4'b0001,
    ECRMW_READ   = 4'b0010,
    ECRMW_MODIFY = 4'b0100,
    ECRMW_WRITE  = 4'b1000
  } ecrmw_state_e;

  typedef struct packed {
    logic [NSYNC-1:0]  sy1;
    logic [NSYNC-1:0]  sy2;
    logic [NSYNC-1:0]  sy3;
    logic [NSYNC-1:0]  pin;
    ecrmw_state_e      state;
    logic [3:0]        cnt;
    logic [DATA_W-1:0] raw_data;
    logic [CHK_W-1:0]  raw_chk;
    logic [CHK_W-1:0]  syn_log;
    logic [DATA_W-1:0] wr_data;
    logic [CHK_W-1:0]  wr_chk;
    logic [DATA_W-1:0] bus_data;
    logic [CHK_W-1:0]  pin_word;
    logic              err;
    logic              corr;
    logic              rw_sel;
    logic              we_n;
    logic              lo_mark_n;
    logic              hi_mark_n;
    logic [1:0]        do_oe_n;
    logic              lo_xcv_oe_n;
    logic              hi_xcv_oe_n;
  } ecrmw_s;

endpackage

// ---- verilog/ecrmw_core.sv ----
// Purpose: Glue and error-correction logic for a single-cycle read-modify-write DRAM port
// Assumes: Controller makes column strobe and transfer acknowledge; pins are asynchronous
// Notes:   Array data is sampled only at fixed points after the strobe, so it is not synced

`timescale 1ns/10ps
`default_nettype none

module ecrmw_core (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        sync_clr,
  input  wire logic        cas_n,
  input  wire logic        transfer_ack_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        mem_cs_n,
  input  wire logic        addr_a0,
  input  wire logic        high_byte_enable_n,
  input  wire logic [15:0] dram_rdata,
  input  wire logic [5:0]  dram_rchk,
  input  wire logic [15:0] corrected_data_port_i,
  output logic      [15:0] corrected_data_port_o,
  output logic      [1:0]  corrected_data_port_oe_n,
  output logic      [15:0] dram_wdata,
  output logic      [5:0]  dram_wchk,
  output logic      [5:0]  syndrome_check_port,
  output logic      [5:0]  syndrome_log,
  output logic             read_write_sel,
  output logic             dram_we_n,
  output logic             error_flag,
  output logic             correctable_flag,
  output logic             low_byte_mark_n,
  output logic             high_byte_mark_n,
  output logic             low_transceiver_oe_n,
  output logic             high_transceiver_oe_n
);

  // ==========================================================================
  // Check code helpers
  // ==========================================================================
  function automatic logic [5:0] chk_gen(input logic [15:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < 16; i++) begin
      if (d[i]) begin
        c = c ^ ecrmw_pkg::HCOL[i];
      end
    end
    return c;
  endfunction

  function automatic logic [15:0] flip_mask(input logic [5:0] s);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      m[i] = (s == ecrmw_pkg::HCOL[i]);
    end
    return m;
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  ecrmw_pkg::ecrmw_s q;
  ecrmw_pkg::ecrmw_s d;

  logic [5:0]  syn;
  logic [15:0] flips;
  logic        chk_single;
  logic        any_err;
  logic        can_fix;
  logic [15:0] fixed_data;
  logic [15:0] merged;
  logic        cas_act;
  logic        ack_act;
  logic        rd_act;
  logic        wr_act;
  logic        cs_act;

  assign cas_act = ~q.pin[ecrmw_pkg::SY_CAS];
  assign ack_act = ~q.pin[ecrmw_pkg::SY_ACK];
  assign rd_act  = ~q.pin[ecrmw_pkg::SY_RD];
  assign wr_act  = ~q.pin[ecrmw_pkg::SY_WR];
  assign cs_act  = ~q.pin[ecrmw_pkg::SY_CS];

  // ==========================================================================
  // Correction datapath
  // ==========================================================================
  always_comb begin
    syn        = chk_gen(q.raw_data) ^ q.raw_chk;
    flips      = flip_mask(syn);
    chk_single = ($countones(syn) == 1);
    any_err    = (syn != 6'h00);
    can_fix    = ~any_err | chk_single | (flips != 16'h0000);
    // Check-bit errors leave data alone; their fix comes from regenerating checks
    fixed_data = can_fix ? (q.raw_data ^ flips) : q.raw_data;
    merged     = fixed_data;
    if (!q.lo_mark_n) begin
      merged[7:0] = corrected_data_port_i[7:0];
    end
    if (!q.hi_mark_n) begin
      merged[15:8] = corrected_data_port_i[15:8];
    end
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    d = q;

    // Three-stage sampling; a level counts once stages two and three agree
    d.sy1 = {high_byte_enable_n, addr_a0, mem_cs_n, wr_n, rd_n, transfer_ack_n, cas_n};
    d.sy2 = q.sy1;
    d.sy3 = q.sy2;
    d.pin = (q.sy2 & q.sy3) | (q.pin & (q.sy2 ^ q.sy3));

    // Byte marks follow the request on writes, inactive on reads
    d.lo_mark_n = ~(wr_act & cs_act) | q.pin[ecrmw_pkg::SY_A0];
    d.hi_mark_n = ~(wr_act & cs_act) | q.pin[ecrmw_pkg::SY_BHE];
    d.do_oe_n   = {~d.hi_mark_n, ~d.lo_mark_n};

    // Only requested bytes reach the bus, only under a qualified command
    d.lo_xcv_oe_n = ~(cs_act & (rd_act | wr_act) & ~q.pin[ecrmw_pkg::SY_A0]);
    d.hi_xcv_oe_n = ~(cs_act & (rd_act | wr_act) & ~q.pin[ecrmw_pkg::SY_BHE]);

    // Acknowledge closes the latch so data outlives the column strobe
    if (!ack_act) begin
      d.bus_data = fixed_data;
    end

    // Shared pins: live syndrome in read phase, write checks afterwards
    d.pin_word = q.rw_sel ? syn : q.wr_chk;

    case (q.state)
      ecrmw_pkg::ECRMW_IDLE: begin
        d.rw_sel = 1'b1;
        d.we_n   = 1'b1;
        d.cnt    = 4'h0;
        if (cas_act) begin
          d.state    = ecrmw_pkg::ECRMW_READ;
          d.cnt      = 4'h1;
          d.raw_data = dram_rdata;
          d.raw_chk  = dram_rchk;
        end
      end
      ecrmw_pkg::ECRMW_READ: begin
        d.raw_data = dram_rdata;
        d.raw_chk  = dram_rchk;
        d.cnt      = q.cnt + 4'h1;
        d.err      = any_err;
        d.corr     = can_fix;
        if (!cas_act) begin
          d.state = ecrmw_pkg::ECRMW_IDLE;
        end else if (q.cnt == ecrmw_pkg::CNT_D1) begin
          // Read phase ends: freeze syndrome and build the write-back word
          d.state   = ecrmw_pkg::ECRMW_MODIFY;
          d.rw_sel  = 1'b0;
          d.syn_log = syn;
          if (can_fix) begin
            d.wr_data = merged;
            d.wr_chk  = chk_gen(merged);
          end else begin
            d.wr_data = q.raw_data;
            d.wr_chk  = q.raw_chk;
          end
        end
      end
      ecrmw_pkg::ECRMW_MODIFY: begin
        d.cnt = q.cnt + 4'h1;
        if (!cas_act) begin
          d.state  = ecrmw_pkg::ECRMW_IDLE;
          d.rw_sel = 1'b1;
        end else if (q.cnt == ecrmw_pkg::CNT_D2) begin
          d.state = ecrmw_pkg::ECRMW_WRITE;
          d.we_n  = 1'b0;
        end
      end
      ecrmw_pkg::ECRMW_WRITE: begin
        if (!cas_act) begin
          d.state  = ecrmw_pkg::ECRMW_IDLE;
          d.we_n   = 1'b1;
          d.rw_sel = 1'b1;
        end
      end
      default: begin
        d.state  = ecrmw_pkg::ECRMW_IDLE;
        d.rw_sel = 1'b1;
        d.we_n   = 1'b1;
      end
    endcase

    // Synchronous clear stops any cycle and releases both strobes
    if (sync_clr) begin
      d.state  = ecrmw_pkg::ECRMW_IDLE;
      d.cnt    = 4'h0;
      d.rw_sel = 1'b1;
      d.we_n   = 1'b1;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q.sy1         <= ecrmw_pkg::SYNC_RST;
      q.sy2         <= ecrmw_pkg::SYNC_RST;
      q.sy3         <= ecrmw_pkg::SYNC_RST;
      q.pin         <= ecrmw_pkg::SYNC_RST;
      q.state       <= ecrmw_pkg::ECRMW_IDLE;
      q.cnt         <= 4'h0;
      q.raw_data    <= 16'h0000;
      q.raw_chk     <= 6'h00;
      q.syn_log     <= 6'h00;
      q.wr_data     <= 16'h0000;
      q.wr_chk      <= 6'h00;
      q.bus_data    <= 16'h0000;
      q.pin_word    <= 6'h00;
      q.err         <= 1'b0;
      q.corr        <= 1'b1;
      q.rw_sel      <= 1'b1;
      q.we_n        <= 1'b1;
      q.lo_mark_n   <= 1'b1;
      q.hi_mark_n   <= 1'b1;
      q.do_oe_n     <= 2'h0;
      q.lo_xcv_oe_n <= 1'b1;
      q.hi_xcv_oe_n <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign corrected_data_port_o    = q.bus_data;
  assign corrected_data_port_oe_n = q.do_oe_n;
  assign dram_wdata               = q.wr_data;
  assign dram_wchk                = q.wr_chk;
  assign syndrome_check_port      = q.pin_word;
  assign syndrome_log             = q.syn_log;
  assign read_write_sel           = q.rw_sel;
  assign dram_we_n                = q.we_n;
  assign error_flag               = q.err;
  assign correctable_flag         = q.corr;
  assign low_byte_mark_n          = q.lo_mark_n;
  assign high_byte_mark_n         = q.hi_mark_n;
  assign low_transceiver_oe_n     = q.lo_xcv_oe_n;
  assign high_transceiver_oe_n    = q.hi_xcv_oe_n;

endmodule

`default_nettype wire

// ---- bench/ecrmw_ctrl_model.sv ----
// Purpose: Memory controller and single-word array on the far side of the block
// Assumes: One request per go pulse; the bench preloads the word before each request
// Notes:   Array outputs invert while the column strobe is high
`timescale 1ns/10ps
`default_nettype none
module ecrmw_ctrl_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        pre_we,
  input  wire logic [15:0] pre_d,
  input  wire logic [5:0]  pre_c,
  input  wire logic        dram_we_n,
  input  wire logic [15:0] dram_wdata,
  input  wire logic [5:0]  dram_wchk,
  output logic             cas_n,
  output logic             transfer_ack_n,
  output logic [15:0]      dram_rdata,
  output logic [5:0]       dram_rchk,
  output logic             done,
  output logic [15:0]      mem_d,
  output logic [5:0]       mem_c
);
  // ==========
  // Strobe sequencing
  int t;
  initial begin
    t = 0;
    cas_n = 1'b1;
    transfer_ack_n = 1'b1;
    done = 1'b0;
  end
  assign dram_rdata = cas_n ? ~mem_d : mem_d;
  assign dram_rchk  = cas_n ? ~mem_c : mem_c;
  always @(posedge clk) begin
    if (pre_we)
      mem_d <= pre_d;
    if (pre_we)
      mem_c <= pre_c;
    if (!pre_we && !dram_we_n && !cas_n) begin
      mem_d <= dram_wdata;
      mem_c <= dram_wchk;
    end
    cas_n <= !((t == 0 && go) || (t >= 1 && t < 16));
    transfer_ack_n <= !(t >= 8 && t < 22);
    done <= (t == 21);
    if (t == 0)
      t <= go ? 1 : 0;
    else
      t <= (t == 30) ? 0 : t + 1;
  end
endmodule
`default_nettype wire

// ---- bench/ecrmw_core_monitor.sv ----
// Purpose: Port checker for the read-modify-write block
// Assumes: One clock domain, reset active high
// Notes:   Pin-to-output lag is four to six edges
`timescale 1ns/10ps
`default_nettype none
module ecrmw_core_monitor (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        sync_clr,
  input wire logic        cas_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        mem_cs_n,
  input wire logic [15:0] dram_rdata,
  input wire logic [5:0]  dram_rchk,
  input wire logic [15:0] dram_wdata,
  input wire logic [5:0]  dram_wchk,
  input wire logic [5:0]  syndrome_log,
  input wire logic        read_write_sel,
  input wire logic        dram_we_n,
  input wire logic        error_flag,
  input wire logic        correctable_flag,
  input wire logic        low_byte_mark_n,
  input wire logic        high_byte_mark_n,
  input wire logic        low_transceiver_oe_n,
  input wire logic        high_transceiver_oe_n
);
  // ==========
  // Properties
  logic cmd_ok;
  logic wr_ok;
  assign cmd_ok = !mem_cs_n && (!rd_n || !wr_n);
  assign wr_ok  = !mem_cs_n && !wr_n;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  we_after_sel_a: assert property ($fell(read_write_sel) && !sync_clr && !cas_n
    |=> $fell(dram_we_n)) else $error("write strobe not one edge after select fall");
  sel_delay_a: assert property ($fell(read_write_sel)
    |-> !$past(cas_n, 2) && !$past(cas_n, 6))
    else $error("select fell too soon after column strobe");
  we_in_write_a: assert property (!dram_we_n |-> !read_write_sel)
    else $error("write strobe low in read phase");
  flag_pair_a: assert property (!correctable_flag |-> error_flag)
    else $error("uncorrectable without error flag");
  uncorr_keep_a: assert property ($fell(read_write_sel) && !correctable_flag
    |-> dram_wdata == dram_rdata && dram_wchk == dram_rchk) else $error("bad word changed");
  clean_keep_a: assert property ($fell(read_write_sel) && !error_flag && low_byte_mark_n
    && high_byte_mark_n |-> dram_wdata == dram_rdata) else $error("clean word changed");
  xcv_gate_a: assert property (!low_transceiver_oe_n || !high_transceiver_oe_n
    |-> $past(cmd_ok, 4) || $past(cmd_ok, 5) || $past(cmd_ok, 6))
    else $error("transceiver on without command");
  mark_write_a: assert property (!low_byte_mark_n || !high_byte_mark_n
    |-> $past(wr_ok, 4) || $past(wr_ok, 5) || $past(wr_ok, 6)) else $error("mark on read");
  log_hold_a: assert property (!read_write_sel && !$fell(read_write_sel)
    |-> $stable(syndrome_log)) else $error("syndrome log moved");
  idle_strobe_a: assert property (cas_n [*8] |-> dram_we_n && read_write_sel)
    else $error("strobes active while idle");
  cover property ($fell(read_write_sel));
  cover property ($fell(correctable_flag));
  cover property (!high_byte_mark_n && !dram_we_n);
endmodule
bind ecrmw_core ecrmw_core_monitor i_ecrmw_core_monitor (
  .clk                   (clk),
  .sys_rst               (sys_rst),
  .sync_clr              (sync_clr),
  .cas_n                 (cas_n),
  .rd_n                  (rd_n),
  .wr_n                  (wr_n),
  .mem_cs_n              (mem_cs_n),
  .dram_rdata            (dram_rdata),
  .dram_rchk             (dram_rchk),
  .dram_wdata            (dram_wdata),
  .dram_wchk             (dram_wchk),
  .syndrome_log          (syndrome_log),
  .read_write_sel        (read_write_sel),
  .dram_we_n             (dram_we_n),
  .error_flag            (error_flag),
  .correctable_flag      (correctable_flag),
  .low_byte_mark_n       (low_byte_mark_n),
  .high_byte_mark_n      (high_byte_mark_n),
  .low_transceiver_oe_n  (low_transceiver_oe_n),
  .high_transceiver_oe_n (high_transceiver_oe_n)
);
`default_nettype wire

// ---- bench/ecrmw_core_test.sv ----
// Purpose: Self-checking bench for the read-modify-write block
// Assumes: Controller model runs one cycle per request
// Notes:   Expected words come from the package check matrix
`timescale 1ns/10ps
`default_nettype none
module ecrmw_core_test;
  logic        clk, sys_rst, sync_clr, cas_n, ack_n, rd_n, wr_n, mem_cs_n, a0, bhe_n;
  logic        go, pre_we, done, rw, we, err, ce, lom, him, lox, hix, clk_en;
  logic [15:0] rdata, wdata, cdi, cdo, pre_d, mem_d;
  logic [5:0]  rchk, wchk, syn, slog, pre_c, mem_c;
  logic [1:0]  cd_oe;
  int          err_total, num_checks, cyc;
  ecrmw_core i_ecrmw_core (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .sync_clr(sync_clr),
    .cas_n(cas_n), .transfer_ack_n(ack_n), .rd_n(rd_n), .wr_n(wr_n), .mem_cs_n(mem_cs_n),
    .addr_a0(a0), .high_byte_enable_n(bhe_n), .dram_rdata(rdata), .dram_rchk(rchk),
    .corrected_data_port_i(cdi), .corrected_data_port_o(cdo),
    .corrected_data_port_oe_n(cd_oe), .dram_wdata(wdata), .dram_wchk(wchk),
    .syndrome_check_port(syn), .syndrome_log(slog), .read_write_sel(rw), .dram_we_n(we),
    .error_flag(err), .correctable_flag(ce), .low_byte_mark_n(lom), .high_byte_mark_n(him),
    .low_transceiver_oe_n(lox), .high_transceiver_oe_n(hix));
  ecrmw_ctrl_model i_ecrmw_ctrl_model (.clk(clk), .go(go), .pre_we(pre_we), .pre_d(pre_d),
    .pre_c(pre_c), .dram_we_n(we), .dram_wdata(wdata), .dram_wchk(wchk), .cas_n(cas_n),
    .transfer_ack_n(ack_n), .dram_rdata(rdata), .dram_rchk(rchk), .done(done),
    .mem_d(mem_d), .mem_c(mem_c));
  // ==========
  // Tasks
  function automatic logic [5:0] gen(input logic [15:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < 16; i++)
      if (d[i])
        c ^= ecrmw_pkg::HCOL[i];
    return c;
  endfunction
  task automatic chk(input logic [21:0] got, input logic [21:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(done, 1'b1, "done");
  endtask
  task automatic run(input logic w, x0, xb, input logic [15:0] b, fd, nd,
                     input logic [5:0] fc, input logic ue);
    logic [15:0] ex;
    logic [5:0]  sy;
    int          n;
    sy = gen(b ^ fd) ^ gen(b) ^ fc;
    ex = ue ? b ^ fd : {w && !xb ? nd[15:8] : b[15:8], w && !x0 ? nd[7:0] : b[7:0]};
    pre_we <= 1'b1;
    pre_d <= b ^ fd;
    pre_c <= gen(b) ^ fc;
    rd_n <= w;
    wr_n <= !w;
    mem_cs_n <= 1'b0;
    a0 <= x0;
    bhe_n <= xb;
    cdi <= nd;
    @(posedge clk) pre_we <= 1'b0;
    repeat (7) @(posedge clk);
    chk({lox, hix, lom, him, cd_oe}, {x0, xb, w ? {x0, xb, !xb, !x0} : 4'hc}, "bus");
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    n = 0;
    while (rw !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(rw, 1'b0, "select fall");
    chk({err, ce, slog, syn}, {|{fd, fc}, !ue, sy, sy}, "flags");
    wait_done();
    if (!w)
      chk(cdo, ue ? b ^ fd : b, "read data");
    chk({mem_d, mem_c}, {ex, ue ? gen(b) ^ fc : gen(ex)}, "stored");
    chk(syn, ue ? gen(b) ^ fc : gen(ex), "check out");
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    mem_cs_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk({lox, hix, lom, him}, 4'hf, "idle");
    $display("test done at %0t", $time);
  endtask
  // ==========
  // Sequence
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    {sys_rst, rd_n, wr_n, mem_cs_n, a0, bhe_n} = 6'h3f;
    {sync_clr, go, pre_we, cdi, pre_d, pre_c} = 0;
    clk_en = 1'b1;
    {err_total, num_checks, cyc} = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk({rw, we, err, ce}, 4'hd, "reset");
    run(0, 0, 1, 16'h5a3c, 16'h0000, 16'h0000, 6'h00, 0);
    run(0, 1, 0, 16'hc3a5, 16'h0100, 16'h0000, 6'h00, 0);
    run(0, 0, 0, 16'h0ff0, 16'h0000, 16'h0000, 6'h04, 0);
    run(0, 0, 1, 16'h1357, 16'h0011, 16'h0000, 6'h00, 1);
    run(1, 0, 1, 16'h2468, 16'h0400, 16'h00ab, 6'h00, 0);
    run(1, 1, 0, 16'hf00f, 16'h0000, 16'hcd00, 6'h00, 0);
    run(1, 0, 0, 16'h8001, 16'h0000, 16'hbeef, 6'h00, 0);
    run(1, 0, 1, 16'h7777, 16'h0000, 16'h0011, 6'h30, 1);
    pre_we <= 1'b1;
    pre_d <= 16'h1224;
    pre_c <= gen(16'h1234);
    rd_n <= 1'b0;
    @(posedge clk) pre_we <= 1'b0;
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (3) @(posedge clk);
    sync_clr <= 1'b1;
    wait_done();
    repeat (3) @(posedge clk);
    sync_clr <= 1'b0;
    chk({mem_d, mem_c}, {16'h1224, gen(16'h1234)}, "abort");
    chk({lox, hix}, 2'h3, "no select");
    $display("test done at %0t", $time);
    // Frozen clock enable holds the old selects until released
    clk_en <= 1'b0;
    mem_cs_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk({lox, hix}, 2'h3, "frozen");
    clk_en <= 1'b1;
    repeat (6) @(posedge clk);
    chk({lox, hix}, 2'h1, "enabled");
    $display("test done at %0t", $time);
    end_sim();
  end
endmodule
`default_nettype wire
